// ===== design/utx_top.sv
/*
  Transmit holding FIFO, prescaler, baud generator, serialiser and
  ready flags of one UART channel, plus the 8-bit host register port.
  Assumes host pins and the oscillator input are asynchronous to mclk,
  and that receive FIFO status arrives from logic on mclk.
*/
// Summary of operation
// (R1) FIFO enable and block bits select mode
// (R2) Receive ready low while receive data held
// (R3) Block mode: fall at trigger, rise empty
// (R4) Transmit ready low while holding empty
// (R5) Block mode: transmit ready high only full
// (R6) Host access needs no oscillator activity
// (R7) Prescale oscillator by 1 or 4
// (R8) Divide by programmed divisor for 16x
// (R9) Divisor split into high and low bytes
// (R10) 16x clock times shifting and sampling
// (R11) Each bit lasts sixteen 16x periods
// (R12) Start, data, optional parity, stop bits
// (R13) Data sent least significant bit first
// (R14) Holding writes fill the transmit FIFO
// (R15) Holding register is write-only, 8 bits
// (R16) Holding empty set when byte moves
// (R17) Enabled holding-empty raises transmit interrupt
// (R18) Shifter empty flag after last bit
// (R19) Host writes one byte at a time
// (R20) Idle shifter loads at next bit boundary
`timescale 1ns/1ps

// --------------------------------------------------
// Generic synchronous FIFO
// --------------------------------------------------
module utx_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  localparam logic [AW-1:0] LAST = AW'(D - 1);
  localparam logic [CW-1:0] FULL = CW'(D);

  if (D < 2) begin : g_chk
    $error("utx_fifo depth below two");
  end

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic push, pop;

  assign in_ready = (cnt_ff != FULL);
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem[rd_ff];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointers wrap explicitly so any depth works, not just powers of two
  always_comb begin
    nxt_wr = push ? ((wr_ff == LAST) ? '0 : AW'(wr_ff + 1'b1)) : wr_ff;
    nxt_rd = pop ? ((rd_ff == LAST) ? '0 : AW'(rd_ff + 1'b1)) : rd_ff;
    nxt_cnt = CW'(cnt_ff + CW'(push) - CW'(pop));
  end

  // Pointer and count registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  // Storage needs no reset
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ff] <= in_data;
    end
  end
endmodule // utx_fifo

// --------------------------------------------------
// Channel top
// --------------------------------------------------
module utx_top #(
  parameter int TX_DEPTH = 64
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Host bus pins
  input wire logic cs_n,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] d_in,
  output logic [7:0] d_out,
  output logic d_oe,
  // Oscillator and serial line
  input wire logic osc_in,
  output logic txd,
  output logic sample_tick,
  // Receive FIFO status from the receiver
  input wire logic rx_avail,
  input wire logic rx_trig,
  input wire logic rx_timeout,
  // Ready pins
  output logic receive_ready_n,
  output logic transmit_ready_n
);
  if (TX_DEPTH < 2) begin : g_chk
    $error("utx_top TX_DEPTH below two");
  end

  // Build the frame LSB first: returns {bit count, 12-bit frame}
  function automatic logic [15:0] mk_frame(input logic [7:0] lcr, input logic [7:0] d);
    logic [11:0] f;
    logic [3:0] p;
    logic [7:0] m;
    logic par;
    f = 12'hfff;
    f[0] = 1'b0; // R12
    m = 8'hff >> (2'h3 - lcr[1:0]);
    for (int i = 0; i < 8; i++) begin
      if (m[i]) begin
        f[i + 1] = d[i]; // R13
      end
    end
    p = 4'h6 + {2'h0, lcr[1:0]};
    par = lcr[utx_pkg::LCR_STICK] ? ~lcr[utx_pkg::LCR_EVEN]
                                  : (^(d & m)) ^ ~lcr[utx_pkg::LCR_EVEN];
    if (lcr[utx_pkg::LCR_PEN]) begin
      f[p] = par; // R12
      p = p + 4'h1;
    end
    p = p + 4'h1 + {3'h0, lcr[utx_pkg::LCR_STOP]};
    return {p, f};
  endfunction

  // ------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------
  logic [14:0] pin_s1_ff, pin_s2_ff;
  logic prev_wr_ff, prev_rd_ff, prev_osc_ff;
  logic wr_act, rd_act, wr_stb, rd_stb, osc_tick;
  logic [2:0] s_addr;
  logic [7:0] s_data;

  // All pins sample through two flops; strobes are edge-detected after
  assign wr_act = ~pin_s2_ff[13] & ~pin_s2_ff[11];
  assign rd_act = ~pin_s2_ff[13] & ~pin_s2_ff[12];
  assign wr_stb = wr_act & ~prev_wr_ff;
  assign rd_stb = rd_act & ~prev_rd_ff;
  assign osc_tick = pin_s2_ff[14] & ~prev_osc_ff;
  assign s_addr = pin_s2_ff[10:8];
  assign s_data = pin_s2_ff[7:0];

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_ff <= utx_pkg::PIN_RST;
      pin_s2_ff <= utx_pkg::PIN_RST;
      prev_wr_ff <= 1'b0;
      prev_rd_ff <= 1'b0;
      prev_osc_ff <= 1'b0;
    end else begin
      pin_s1_ff <= {osc_in, cs_n, ior_n, iow_n, addr, d_in};
      pin_s2_ff <= pin_s1_ff;
      prev_wr_ff <= wr_act;
      prev_rd_ff <= rd_act;
      prev_osc_ff <= pin_s2_ff[14];
    end
  end

  // ------------------------------------------------
  // Host registers
  // ------------------------------------------------
  utx_pkg::utx_state_t tx_state_ff, nxt_state;
  logic [7:0] ien_ff, nxt_ien, lcr_ff, nxt_lcr, mctl_ff, nxt_mctl;
  logic [7:0] dll_ff, nxt_dll, dvh_ff, nxt_dvh, dout_ff, nxt_dout;
  logic fen_ff, nxt_fen, fblk_ff, nxt_fblk, oe_ff, nxt_oe;
  logic dlab, blk, wr_hold, ist_rd, thre, temt, tx_int_ff;
  logic fifo_ov, fifo_in_ready, pop;
  logic [7:0] ist_val, fifo_data;

  assign dlab = lcr_ff[utx_pkg::LCR_DLAB];
  assign blk = fen_ff & fblk_ff; // R1
  assign wr_hold = wr_stb & (s_addr == utx_pkg::A_DATA) & ~dlab; // R15
  assign ist_rd = rd_stb & (s_addr == utx_pkg::A_IST);
  assign thre = ~fifo_ov;
  assign temt = thre & (tx_state_ff == utx_pkg::TX_IDLE); // R18
  assign ist_val = (tx_int_ff & ien_ff[utx_pkg::IEN_HOLD]) ? utx_pkg::IST_TX
                                                          : utx_pkg::IST_NONE; // R17

  // Register accesses run on mclk only, never on the oscillator
  always_comb begin // R6
    nxt_ien = ien_ff;
    nxt_lcr = lcr_ff;
    nxt_mctl = mctl_ff;
    nxt_dll = dll_ff;
    nxt_dvh = dvh_ff;
    nxt_fen = fen_ff;
    nxt_fblk = fblk_ff;
    nxt_dout = dout_ff;
    nxt_oe = rd_act;
    if (wr_stb) begin
      case (s_addr)
        utx_pkg::A_DATA: if (dlab) nxt_dll = s_data; // R9
        utx_pkg::A_IEN: begin
          if (dlab) nxt_dvh = s_data; // R9
          else nxt_ien = s_data;
        end
        utx_pkg::A_IST: begin
          nxt_fen = s_data[utx_pkg::FCTL_EN]; // R1
          nxt_fblk = s_data[utx_pkg::FCTL_BLK]; // R1
        end
        utx_pkg::A_LCR: nxt_lcr = s_data;
        utx_pkg::A_MCTL: nxt_mctl = s_data;
        default: ;
      endcase
    end
    if (rd_stb) begin
      case (s_addr)
        utx_pkg::A_DATA: nxt_dout = dlab ? dll_ff : 8'h00; // R15
        utx_pkg::A_IEN: nxt_dout = dlab ? dvh_ff : ien_ff;
        utx_pkg::A_IST: nxt_dout = ist_val;
        utx_pkg::A_LCR: nxt_dout = lcr_ff;
        utx_pkg::A_MCTL: nxt_dout = mctl_ff;
        utx_pkg::A_LSTAT: nxt_dout = {1'b0, temt, thre, 4'h0, rx_avail};
        default: nxt_dout = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ien_ff <= utx_pkg::REG_RST;
      lcr_ff <= utx_pkg::REG_RST;
      mctl_ff <= utx_pkg::REG_RST;
      dll_ff <= utx_pkg::DLL_RST;
      dvh_ff <= utx_pkg::REG_RST;
      dout_ff <= utx_pkg::REG_RST;
      fen_ff <= 1'b0;
      fblk_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      ien_ff <= nxt_ien;
      lcr_ff <= nxt_lcr;
      mctl_ff <= nxt_mctl;
      dll_ff <= nxt_dll;
      dvh_ff <= nxt_dvh;
      dout_ff <= nxt_dout;
      fen_ff <= nxt_fen;
      fblk_ff <= nxt_fblk;
      oe_ff <= nxt_oe;
    end
  end

  // ------------------------------------------------
  // Transmit FIFO
  // ------------------------------------------------
  // Without FIFO mode only an empty FIFO accepts, so it acts as one holder
  utx_fifo #(.W(8), .D(TX_DEPTH)) u_fifo (
    .mclk(mclk),
    .arst_n(arst_n),
    .in_valid(wr_hold & (fen_ff | thre)), // R14 R19
    .in_ready(fifo_in_ready),
    .in_data(s_data),
    .out_valid(fifo_ov),
    .out_ready(pop),
    .out_data(fifo_data)
  );

  // ------------------------------------------------
  // Prescaler and baud generator
  // ------------------------------------------------
  logic [1:0] pre_ff, nxt_pre;
  logic [15:0] div_ff, nxt_div, divisor;
  logic [3:0] sub_ff, nxt_sub;
  logic tick_ff, pre_tick, div_hit, bit_end;

  assign divisor = {dvh_ff, dll_ff}; // R9
  assign pre_tick = osc_tick & (~mctl_ff[utx_pkg::MCTL_PRE4]
                                | (pre_ff == utx_pkg::PRE4_LAST)); // R7
  // A zero divisor stops the generator rather than dividing by 65536
  assign div_hit = pre_tick & (|divisor) & ({1'b0, div_ff} + 17'h1 >= {1'b0, divisor}); // R8
  assign bit_end = div_hit & (sub_ff == utx_pkg::BIT_LAST); // R11

  always_comb begin
    nxt_pre = osc_tick ? 2'(pre_ff + 2'h1) : pre_ff;
    nxt_div = div_ff;
    if (pre_tick) begin
      nxt_div = div_hit ? 16'h0000 : 16'(div_ff + 16'h1); // R8
    end
    nxt_sub = div_hit ? 4'(sub_ff + 4'h1) : sub_ff; // R10
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pre_ff <= 2'h0;
      div_ff <= 16'h0000;
      sub_ff <= 4'h0;
      tick_ff <= 1'b0;
    end else begin
      pre_ff <= nxt_pre;
      div_ff <= nxt_div;
      sub_ff <= nxt_sub;
      tick_ff <= div_hit; // R10
    end
  end

  // ------------------------------------------------
  // Transmit shifter
  // ------------------------------------------------
  logic [11:0] sh_ff, nxt_sh;
  logic [3:0] left_ff, nxt_left;
  logic txd_ff, nxt_txd, load;
  logic [15:0] frm;

  assign frm = mk_frame(lcr_ff, fifo_data);
  // Back-to-back frames: load again in the last stop bit's boundary
  assign load = bit_end & fifo_ov & ((tx_state_ff == utx_pkg::TX_IDLE) | (left_ff == 4'h0)); // R20
  assign pop = load; // R16

  always_comb begin
    nxt_state = tx_state_ff;
    nxt_sh = sh_ff;
    nxt_left = left_ff;
    nxt_txd = txd_ff;
    if (load) begin
      nxt_txd = frm[0]; // R12
      nxt_sh = frm[11:0] >> 1;
      nxt_left = 4'(frm[15:12] - 4'h1);
      nxt_state = utx_pkg::TX_SHIFT;
    end else begin
      case (tx_state_ff)
        utx_pkg::TX_IDLE: nxt_txd = 1'b1;
        utx_pkg::TX_SHIFT: begin
          if (bit_end) begin // R11
            if (left_ff == 4'h0) begin
              nxt_txd = 1'b1;
              nxt_state = utx_pkg::TX_IDLE; // R18
            end else begin
              nxt_txd = sh_ff[0]; // R13
              nxt_sh = sh_ff >> 1;
              nxt_left = 4'(left_ff - 4'h1);
            end
          end
        end
        default: nxt_state = utx_pkg::TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_state_ff <= utx_pkg::TX_IDLE;
      sh_ff <= 12'hfff;
      left_ff <= 4'h0;
      txd_ff <= 1'b1;
    end else begin
      tx_state_ff <= nxt_state;
      sh_ff <= nxt_sh;
      left_ff <= nxt_left;
      txd_ff <= nxt_txd;
    end
  end

  // ------------------------------------------------
  // Interrupt pending and ready pins
  // ------------------------------------------------
  logic thre_prev_ff, nxt_int, rxr_ff, nxt_rxr, txr_ff, nxt_txr;

  // Set beats a clearing status read or holding write in the same cycle
  always_comb begin
    nxt_int = (thre & ~thre_prev_ff) | (tx_int_ff & ~(ist_rd | wr_hold)); // R16 R17
    if (blk) begin
      if (rx_trig | rx_timeout) nxt_rxr = 1'b0; // R3
      else if (!rx_avail) nxt_rxr = 1'b1; // R3
      else nxt_rxr = rxr_ff;
      nxt_txr = ~fifo_in_ready; // R5
    end else begin
      nxt_rxr = ~rx_avail; // R2
      nxt_txr = fifo_ov; // R4
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      thre_prev_ff <= 1'b1;
      tx_int_ff <= 1'b0;
      rxr_ff <= 1'b1;
      txr_ff <= 1'b0;
    end else begin
      thre_prev_ff <= thre;
      tx_int_ff <= nxt_int;
      rxr_ff <= nxt_rxr;
      txr_ff <= nxt_txr;
    end
  end

  assign d_out = dout_ff;
  assign d_oe = oe_ff;
  assign txd = txd_ff;
  assign sample_tick = tick_ff;
  assign receive_ready_n = rxr_ff;
  assign transmit_ready_n = txr_ff;

  // ------------------------------------------------
  // Checks
  // ------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_full2;
    (blk && !fifo_in_ready) ##1 (blk && !fifo_in_ready);
  endsequence
  a_block_tx_full: assert property (s_full2 |-> transmit_ready_n) // R5
    else $error("transmit ready not high on full FIFO");
  a_tx_ready_empty: assert property ((!blk && !fifo_ov) [*2] |-> !transmit_ready_n) // R4
    else $error("transmit ready not low on empty holder");
  a_rx_level: assert property (!blk ##1 !blk |-> receive_ready_n == !$past(rx_avail)) // R2
    else $error("receive ready does not follow data");
  a_rx_block_fall: assert property (blk && (rx_trig || rx_timeout) ##1 blk |-> !receive_ready_n) // R3
    else $error("receive ready did not fall at trigger");
  a_rx_block_hold: assert property (blk && !receive_ready_n && rx_avail ##1 blk
                                    |-> !receive_ready_n) // R3
    else $error("receive ready rose before FIFO empty");
  a_bit_hold: assert property ($changed(txd_ff) |-> $past(bit_end)) // R11
    else $error("serial line changed off a bit boundary");
  a_start_bit: assert property (bit_end && fifo_ov && tx_state_ff == utx_pkg::TX_IDLE
                                |=> tx_state_ff == utx_pkg::TX_SHIFT && !txd_ff) // R20
    else $error("idle shifter did not start a frame");
  a_idle_line: assert property (tx_state_ff == utx_pkg::TX_IDLE |-> txd_ff) // R18
    else $error("line low while shifter idle");
  a_thre_event: assert property (thre && !thre_prev_ff |=> tx_int_ff) // R17
    else $error("holding empty event lost");
  a_prescale: assert property (div_ff != $past(div_ff) |-> $past(pre_tick)) // R7
    else $error("divisor counter moved without prescaled tick");
endmodule // utx_top

// ===== inc/utx_pkg.sv
/*
  Shared constants for the UART transmit, baud and ready-flag block.
  Assumes a single-channel instance on one system clock.
*/
package utx_pkg;
  // Register offsets on the three address pins
  localparam logic [2:0] A_DATA = 3'h0;
  localparam logic [2:0] A_IEN = 3'h1;
  localparam logic [2:0] A_IST = 3'h2;
  localparam logic [2:0] A_LCR = 3'h3;
  localparam logic [2:0] A_MCTL = 3'h4;
  localparam logic [2:0] A_LSTAT = 3'h5;
  // Field positions
  localparam int FCTL_EN = 0;
  localparam int FCTL_BLK = 3;
  localparam int IEN_HOLD = 1;
  localparam int LCR_STOP = 2;
  localparam int LCR_PEN = 3;
  localparam int LCR_EVEN = 4;
  localparam int LCR_STICK = 5;
  localparam int LCR_DLAB = 7;
  localparam int MCTL_PRE4 = 7;
  // Reset values
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] DLL_RST = 8'h01;
  localparam logic [14:0] PIN_RST = 15'h3800;
  // Interrupt status codes
  localparam logic [7:0] IST_NONE = 8'h01;
  localparam logic [7:0] IST_TX = 8'h02;
  // Timing counts
  localparam logic [1:0] PRE4_LAST = 2'h3;
  localparam logic [3:0] BIT_LAST = 4'hf;
  typedef enum {TX_IDLE, TX_SHIFT} utx_state_t;
endpackage

// ===== verif/test_utx_top.sv
/*
  Self-checking bench for the UART transmit, baud and ready-flag block.
  Assumes the serial peer model and the design files are compiled first.
*/
`timescale 1ns/1ps
module test_utx_top;
  // ----------------------------------------
  // Pins, peer and frame queue
  // ----------------------------------------
  logic mclk = 1'b0, arst_n = 1'b0, osc_in = 1'b0, osc_run = 1'b1;
  logic cs_n = 1'b1, ior_n = 1'b1, iow_n = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] d_in = 8'h00, d_out, data, lcr_v = 8'h03;
  logic d_oe, txd, sample_tick, receive_ready_n, transmit_ready_n, done, par, frame_ok;
  logic rx_avail = 1'b0, rx_trig = 1'b0, rx_timeout = 1'b0, pen = 1'b0;
  logic [3:0] nbits = 4'h8;
  logic [1:0] nstop = 2'h1;
  logic [31:0] seed = 32'h7232e3d5;
  logic [9:0] rxq [$];
  int miscompares = 0, n_checks = 0;

  initial begin
    forever #4 mclk = ~mclk;
  end
  // Oscillator at a quarter of mclk, phase unrelated; it can be stopped
  initial begin
    #3;
    forever #16 osc_in = ~osc_in & osc_run;
  end

  utx_top #(.TX_DEPTH(8)) dut (.mclk(mclk), .arst_n(arst_n), .cs_n(cs_n), .ior_n(ior_n),
    .iow_n(iow_n), .addr(addr), .d_in(d_in), .d_out(d_out), .d_oe(d_oe), .osc_in(osc_in),
    .txd(txd), .sample_tick(sample_tick), .rx_avail(rx_avail), .rx_trig(rx_trig),
    .rx_timeout(rx_timeout), .receive_ready_n(receive_ready_n),
    .transmit_ready_n(transmit_ready_n));
  utx_serial_peer peer (.mclk(mclk), .arst_n(arst_n), .txd(txd), .sample_tick(sample_tick),
    .nbits(nbits), .pen(pen), .nstop(nstop), .done(done), .data(data), .par(par),
    .frame_ok(frame_ok));

  // Keep every decoded frame until the sequence looks at it
  always @(posedge mclk) begin
    if (done === 1'b1) begin
      rxq.push_back({frame_ok, par, data});
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // Even parity makes the ones even, odd makes them odd; stick forces the bit
  function automatic logic exp_par(input logic [7:0] m, input logic [7:0] lcr);
    if (lcr[utx_pkg::LCR_STICK]) return ~lcr[utx_pkg::LCR_EVEN];
    return ^m ^ ~lcr[utx_pkg::LCR_EVEN];
  endfunction
  task automatic results;
    if (miscompares == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask
  // Pins are asynchronous: hold each strobe and its data 4 cycles either side
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge mclk);
    {cs_n, iow_n, addr, d_in} = {2'b00, a, d};
    repeat (4) @(negedge mclk);
    {cs_n, iow_n} = 2'b11;
    repeat (4) @(negedge mclk);
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] exp, input string what);
    @(negedge mclk);
    {cs_n, ior_n, addr} = {2'b00, a};
    repeat (5) @(negedge mclk);
    chk(what, exp, d_out);
    chk("data drive", 1, d_oe);
    {cs_n, ior_n} = 2'b11;
    repeat (4) @(negedge mclk);
    chk("data release", 0, d_oe);
  endtask
  task automatic wait_trn(input logic v, input int lim);
    for (int i = 0; i < lim && transmit_ready_n !== v; i++) @(negedge mclk);
    if (transmit_ready_n !== v) begin
      miscompares++;
      results();
    end
  endtask
  task automatic wait_frames(input int n);
    for (int i = 0; i < 20000 && rxq.size() < n; i++) @(negedge mclk);
    if (rxq.size() < n) begin
      miscompares++;
      results();
    end
  endtask
  task automatic line_cfg(input logic [7:0] v);
    wr(utx_pkg::A_LCR, v);
    lcr_v = v;
    nbits = {2'b00, v[1:0]} + 4'h5;
    pen = v[utx_pkg::LCR_PEN];
    nstop = v[utx_pkg::LCR_STOP] ? 2'h2 : 2'h1;
  endtask
  task automatic set_div(input logic [15:0] dv);
    wr(utx_pkg::A_LCR, 8'h83);
    wr(utx_pkg::A_DATA, dv[7:0]);
    wr(utx_pkg::A_IEN, dv[15:8]);
    line_cfg(8'h03);
  endtask
  task automatic frame(input logic [7:0] d);
    logic [7:0] m;
    logic [9:0] got;
    m = d & (8'hff >> (4'h8 - nbits));
    got = rxq.pop_front();
    chk("frame data", m, got[7:0]);
    chk("frame timing", 1, got[9]);
    if (pen) chk("parity", exp_par(m, lcr_v), got[8]);
  endtask
  // Gap from the second to the third tick after a change, counted in mclk cycles
  task automatic tick_gap(input int exp);
    int k, n, t;
    k = 0;
    t = 0;
    for (n = 0; k < 3 && n < 9000; n++) begin
      @(negedge mclk);
      if (sample_tick === 1'b1) begin
        k++;
        if (k == 2) t = n;
      end
    end
    chk("tick gap", exp, n - 1 - t);
  endtask
  task automatic rx_case(input logic [7:0] fifo_control, input logic trig, input logic tmo);
    wr(utx_pkg::A_IST, fifo_control);
    rx_avail = 1'b1;
    repeat (3) @(negedge mclk);
    // Block mode waits for the trigger; otherwise any held byte pulls it low
    chk("rx ready held", fifo_control[utx_pkg::FCTL_EN] & fifo_control[utx_pkg::FCTL_BLK], receive_ready_n);
    {rx_trig, rx_timeout} = {trig, tmo};
    @(negedge mclk);
    {rx_trig, rx_timeout} = 2'b00;
    repeat (2) @(negedge mclk);
    chk("rx ready set", 0, receive_ready_n);
    rx_avail = 1'b0;
    repeat (2) @(negedge mclk);
    chk("rx ready empty", 1, receive_ready_n);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int k;
    logic [7:0] bq [3];
    repeat (3) @(negedge mclk);
    arst_n = 1'b1;
    chk("txd idle", 1, txd);
    chk("tx ready", 0, transmit_ready_n);
    chk("rx ready", 1, receive_ready_n);
    // Register access with the oscillator stopped
    osc_run = 1'b0;
    wr(utx_pkg::A_IEN, 8'h02);
    rdc(utx_pkg::A_IEN, 8'h02, "int enable");
    rdc(utx_pkg::A_LSTAT, 8'h60, "status idle");
    osc_run = 1'b1;
    // Divisor bytes and prescaler set the tick spacing
    set_div(16'h0103);
    tick_gap(1036);
    set_div(16'h0003);
    wr(utx_pkg::A_MCTL, 8'h80);
    tick_gap(48);
    wr(utx_pkg::A_MCTL, 8'h00);
    tick_gap(12);
    set_div(16'h0001);
    // No FIFO: second byte waits in the holder, a third one is dropped
    wr(utx_pkg::A_DATA, 8'ha5);
    wait_trn(1'b0, 200);
    wr(utx_pkg::A_DATA, 8'h3c);
    wr(utx_pkg::A_DATA, 8'hff);
    chk("tx ready byte", 1, transmit_ready_n);
    rdc(utx_pkg::A_LSTAT, 8'h00, "status busy");
    wait_trn(1'b0, 1000);
    rdc(utx_pkg::A_LSTAT, 8'h20, "status moved");
    rdc(utx_pkg::A_IST, utx_pkg::IST_TX, "int status set");
    rdc(utx_pkg::A_IST, utx_pkg::IST_NONE, "int status cleared");
    wait_frames(2);
    frame(8'ha5);
    frame(8'h3c);
    repeat (800) @(negedge mclk);
    chk("dropped byte", 0, rxq.size());
    rdc(utx_pkg::A_LSTAT, 8'h60, "status empty");
    // Single-character FIFO mode with random formats; this seed never sets stick parity with parity on
    wr(utx_pkg::A_IEN, 8'h00);
    wr(utx_pkg::A_IST, 8'h01);
    for (k = 0; k < 3; k++) begin
      seed = xs(seed);
      line_cfg({2'b00, seed[5:0]});
      for (int i = 0; i < 3; i++) begin
        seed = xs(seed);
        bq[i] = seed[15:8];
        wr(utx_pkg::A_DATA, bq[i]);
      end
      chk("fifo waiting", 1, transmit_ready_n);
      wait_frames(3);
      for (int i = 0; i < 3; i++) frame(bq[i]);
    end
    // Block mode: byte 0 is shifted first so the FIFO stays full long after
    line_cfg(8'h03);
    wr(utx_pkg::A_IST, 8'h09);
    wr(utx_pkg::A_DATA, 8'h00);
    repeat (80) @(negedge mclk);
    for (k = 1; k < 12 && transmit_ready_n !== 1'b1; k++) wr(utx_pkg::A_DATA, k[7:0]);
    chk("block fill", 9, k);
    wr(utx_pkg::A_DATA, 8'h77);
    wait_frames(k);
    for (int i = 0; i < k; i++) frame(i[7:0]);
    repeat (800) @(negedge mclk);
    chk("full drop", 0, rxq.size());
    chk("block drained", 0, transmit_ready_n);
    // Receive ready in each mode
    rx_case(8'h09, 1'b1, 1'b0);
    rx_case(8'h09, 1'b0, 1'b1);
    rx_case(8'h01, 1'b0, 1'b0);
    rx_case(8'h00, 1'b0, 1'b0);
    results();
  end
endmodule // test_utx_top

// ===== verif/utx_serial_peer.sv
/*
  Serial peer: decodes each frame on txd one 16x tick at a time.
  Assumes the line format inputs stay steady while a frame is on the line.
*/
`timescale 1ns/1ps
module utx_serial_peer (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Line and 16x tick
  input wire logic txd,
  input wire logic sample_tick,
  // Line format
  input wire logic [3:0] nbits,
  input wire logic pen,
  input wire logic [1:0] nstop,
  // Decoded frame
  output logic done,
  output logic [7:0] data,
  output logic par,
  output logic frame_ok
);
  logic busy;
  logic lvl;
  logic [3:0] tcnt, slot;
  // ----------------------------------------
  // Frame decoder
  // ----------------------------------------
  // Any change inside a bit spoils the frame, so a short bit cannot hide
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      {busy, done, par, frame_ok, lvl, tcnt, slot, data} <= '0;
    end else begin
      done <= 1'b0;
      if (sample_tick && !busy && txd === 1'b0) begin
        {busy, frame_ok, lvl, tcnt, slot, data} <= {3'b110, 4'h1, 4'h0, 8'h00};
      end else if (sample_tick && busy) begin
        tcnt <= tcnt + 4'h1;
        if (tcnt == 4'h0) lvl <= txd;
        else if (txd !== lvl) frame_ok <= 1'b0;
        if (tcnt == 4'h8 && slot >= 4'h1 && slot <= nbits) data[slot - 4'h1] <= txd;
        if (tcnt == 4'h8 && pen && slot == nbits + 4'h1) par <= txd;
        if (tcnt == 4'h8 && slot > nbits + pen && txd !== 1'b1) frame_ok <= 1'b0;
        if (tcnt == 4'hf) slot <= slot + 4'h1;
        if (tcnt == 4'hf && slot == nbits + pen + nstop) {busy, done} <= 2'b01;
      end
    end
  end
endmodule // utx_serial_peer
